// ---- include/dsb_pkg.sv ----
`default_nettype none

package dsb_pkg;

    // ****************************************************************
    // widths and storage
    // ****************************************************************
    localparam int WORD_W = 18;          // one data beat
    localparam int LANES = 2;            // byte lanes per word
    localparam int LANE_W = 9;           // bits per byte lane
    localparam int ADDR_W = 5;           // modelled address bits
    localparam int DEPTH = 2 ** ADDR_W;  // stored words
    localparam int BEATS = 2;            // words per address

    // packed pin bundle carried through the synchroniser
    localparam int CLK_BITS = 4;
    localparam int CTL_BITS = 4;
    localparam int PIN_W = CLK_BITS + CTL_BITS + ADDR_W + LANES + WORD_W;

    // ****************************************************************
    // bit positions inside the clock group
    // ****************************************************************
    localparam int CK_K = 0;
    localparam int CK_KN = 1;
    localparam int CK_C = 2;
    localparam int CK_CN = 3;

    // ****************************************************************
    // read latency in launch-clock half periods
    // ****************************************************************
    localparam logic [1:0] LAT_DLL_ON = 2'h3;   // 1.5 cycles
    localparam logic [1:0] LAT_DLL_OFF = 2'h2;  // 1 cycle

    // ****************************************************************
    // output clock presence detection
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int C_TIMEOUT_NS = 400;
    localparam int C_TIMEOUT_INT =
        (C_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] C_TIMEOUT_CYC = C_TIMEOUT_INT[5:0];

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [WORD_W-1:0] DQ_RESET = 18'h0_0000;

    // write sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WORD0 = 4'h2,
        ST_WORD1 = 4'h4,
        ST_COMMIT = 4'h8
    } dsb_wstate_t;

endpackage

`default_nettype wire

// ---- design/dsb_sync2.sv ----
`timescale 1ns/1ps
`default_nettype none

module dsb_sync2 #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    // first stage feeds only the second stage
    always_comb begin
        meta_d = async_in;
        sync_d = meta_q;
    end

    // two flops on every pin, idle high in reset so no false edge follows
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= '1;
            sync_q <= '1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

endmodule

`default_nettype wire

// ---- design/dsb_sram_port.sv ----
// Notes on behaviour
// - address taken on alternate input clock rises
// - write words on input clock, then complement
// - read words launched on output clock pair
// - no output clocks: launch on input pair
// - every address carries two successive words
// - narrow organisation: burst counter starts zero
// - wide organisation: counter loads address bit zero
// - dll on: read latency one and half
// - dll off: read latency one cycle
// - writes finish by internal self timing
// - all synchronous inputs registered first
// - echo clocks follow launched read data
`timescale 1ns/1ps
`default_nettype none

module dsb_sram_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic link_k,
    input wire logic link_k_n,
    input wire logic out_clk_c,
    input wire logic out_clk_c_n,
    input wire logic [dsb_pkg::ADDR_W-1:0] address,
    input wire logic load_strobe_n,
    input wire logic read_write,
    input wire logic [dsb_pkg::LANES-1:0] byte_write_select_n,
    input wire logic [dsb_pkg::WORD_W-1:0] dq_in,
    input wire logic dll_disable,
    input wire logic narrow_org,
    output logic [dsb_pkg::WORD_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic echo_clock,
    output logic echo_clock_n,
    output logic out_clk_used
);
    import dsb_pkg::*;

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_s;
    logic [CLK_BITS-1:0] clk_s;
    logic [CLK_BITS-1:0] clk_prev_q;
    logic [CLK_BITS-1:0] clk_prev_d;
    logic [CLK_BITS-1:0] clk_rise;
    logic ld_n_s;
    logic rw_s;
    logic dll_off_s;
    logic narrow_s;
    logic [ADDR_W-1:0] addr_s;
    logic [LANES-1:0] bws_n_s;
    logic [WORD_W-1:0] dq_s;

    // every pin passes two flops before use
    assign pins_raw = {dq_in, byte_write_select_n, address, narrow_org,
                       dll_disable, read_write, load_strobe_n,
                       out_clk_c_n, out_clk_c, link_k_n, link_k};

    dsb_sync2 #(.W(PIN_W)) u_sync (
        .mclk(mclk),
        .rst(rst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    // unpack the synchronised bundle
    assign clk_s = pins_s[CLK_BITS-1:0];
    assign ld_n_s = pins_s[CLK_BITS];
    assign rw_s = pins_s[CLK_BITS+1];
    assign dll_off_s = pins_s[CLK_BITS+2];
    assign narrow_s = pins_s[CLK_BITS+3];
    assign addr_s = pins_s[CLK_BITS+CTL_BITS +: ADDR_W];
    assign bws_n_s = pins_s[CLK_BITS+CTL_BITS+ADDR_W +: LANES];
    assign dq_s = pins_s[PIN_W-1 -: WORD_W];

    // rising edges of the four link clocks
    assign clk_rise = clk_s & ~clk_prev_q;

    always_comb begin
        clk_prev_d = clk_s;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_prev_q <= '1; // matches idle bundle, no rise after reset
        end else begin
            clk_prev_q <= clk_prev_d;
        end
    end

    // ****************************************************************
    // burst word addressing
    // ****************************************************************
    // word slot for a beat: counter start from a0 or from zero
    function automatic logic [ADDR_W-1:0] word_index(
        input logic [ADDR_W-1:0] addr,
        input logic narrow,
        input logic beat
    );
        logic start;
        start = narrow ? 1'b0 : addr[0];
        word_index = {addr[ADDR_W-1:1], start ^ beat};
    endfunction

    // ****************************************************************
    // output clock presence and launch edge choice
    // ****************************************************************
    logic [5:0] c_idle_q;
    logic [5:0] c_idle_d;
    logic use_c;
    logic launch_edge;

    assign use_c = (c_idle_q < C_TIMEOUT_CYC);

    // output pair counts as present while it keeps toggling
    always_comb begin
        c_idle_d = c_idle_q;
        if (clk_rise[CK_C] | clk_rise[CK_CN]) begin
            c_idle_d = '0;
        end else if (c_idle_q < C_TIMEOUT_CYC) begin
            c_idle_d = c_idle_q + 6'h1;
        end
    end

    // rising edge of either clock of the launch pair
    assign launch_edge = use_c ?
        (clk_rise[CK_C] | clk_rise[CK_CN]) :
        (clk_rise[CK_K] | clk_rise[CK_KN]);

    always_ff @(posedge mclk) begin
        if (rst) begin
            c_idle_q <= C_TIMEOUT_CYC;
        end else begin
            c_idle_q <= c_idle_d;
        end
    end

    // ****************************************************************
    // storage array
    // ****************************************************************
    logic [WORD_W-1:0] mem_q [DEPTH];
    logic [WORD_W-1:0] mem_d [DEPTH];

    // ****************************************************************
    // command capture and write sequencer
    // ****************************************************************
    dsb_wstate_t wst_q;
    dsb_wstate_t wst_d;
    logic alt_q;
    logic alt_d;
    logic [ADDR_W-1:0] wr_addr_q;
    logic [ADDR_W-1:0] wr_addr_d;
    logic wr_narrow_q;
    logic wr_narrow_d;
    logic [WORD_W-1:0] wr_word_q [BEATS];
    logic [WORD_W-1:0] wr_word_d [BEATS];
    logic [LANES-1:0] wr_mask_n_q [BEATS];
    logic [LANES-1:0] wr_mask_n_d [BEATS];
    logic addr_edge;
    logic load_rd;
    logic load_wr;

    // an address edge is a k rise other than the one right after a load
    assign addr_edge = clk_rise[CK_K] & ~alt_q;
    assign load_rd = addr_edge & ~ld_n_s & rw_s;
    assign load_wr = addr_edge & ~ld_n_s & ~rw_s;

    // sequencer next state and captured write beats
    always_comb begin
        wst_d = wst_q;
        alt_d = alt_q;
        wr_addr_d = wr_addr_q;
        wr_narrow_d = wr_narrow_q;
        wr_word_d = wr_word_q;
        wr_mask_n_d = wr_mask_n_q;
        if (load_rd | load_wr) begin
            alt_d = 1'b1;
        end else if (clk_rise[CK_K]) begin
            alt_d = 1'b0;
        end
        unique case (wst_q)
            ST_IDLE: begin
                if (load_wr) begin
                    wr_addr_d = addr_s;
                    wr_narrow_d = narrow_s;
                    wst_d = ST_WORD0;
                end
            end
            ST_WORD0: begin
                if (clk_rise[CK_K]) begin
                    wr_word_d[0] = dq_s;
                    wr_mask_n_d[0] = bws_n_s;
                    wst_d = ST_WORD1;
                end
            end
            ST_WORD1: begin
                if (clk_rise[CK_KN]) begin
                    wr_word_d[1] = dq_s;
                    wr_mask_n_d[1] = bws_n_s;
                    wst_d = ST_COMMIT;
                end
            end
            ST_COMMIT: begin
                wst_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wst_q <= ST_IDLE;
            alt_q <= 1'b0;
            wr_addr_q <= '0;
            wr_narrow_q <= 1'b0;
            wr_word_q <= '{default: '0};
            wr_mask_n_q <= '{default: '1};
        end else begin
            wst_q <= wst_d;
            alt_q <= alt_d;
            wr_addr_q <= wr_addr_d;
            wr_narrow_q <= wr_narrow_d;
            wr_word_q <= wr_word_d;
            wr_mask_n_q <= wr_mask_n_d;
        end
    end

    // self-timed commit of both beats, lane by lane
    always_comb begin
        mem_d = mem_q;
        if (wst_q == ST_COMMIT) begin
            for (int b = 0; b < BEATS; b++) begin
                for (int l = 0; l < LANES; l++) begin
                    if (!wr_mask_n_q[b][l]) begin
                        mem_d[word_index(wr_addr_q, wr_narrow_q,
                              b[0])][l*LANE_W +: LANE_W] =
                            wr_word_q[b][l*LANE_W +: LANE_W];
                    end
                end
            end
        end
    end

    // data array needs no reset
    always_ff @(posedge mclk) begin
        mem_q <= mem_d;
    end

    // ****************************************************************
    // read pipeline and output stage
    // ****************************************************************
    logic rd_busy_q;
    logic rd_busy_d;
    logic [1:0] rd_cnt_q;
    logic [1:0] rd_cnt_d;
    logic [WORD_W-1:0] rd_word0_q;
    logic [WORD_W-1:0] rd_word0_d;
    logic [WORD_W-1:0] rd_word1_q;
    logic [WORD_W-1:0] rd_word1_d;
    logic [WORD_W-1:0] dq_out_q;
    logic [WORD_W-1:0] dq_out_d;
    logic dq_oe_n_q;
    logic dq_oe_n_d;
    logic echo_q;
    logic echo_d;
    logic echo_n_q;
    logic echo_n_d;
    logic used_q;
    logic used_d;

    // count launch edges down to the first word, then send the second
    always_comb begin
        rd_busy_d = rd_busy_q;
        rd_cnt_d = rd_cnt_q;
        rd_word0_d = rd_word0_q;
        rd_word1_d = rd_word1_q;
        dq_out_d = dq_out_q;
        dq_oe_n_d = dq_oe_n_q;
        if (launch_edge) begin
            if (rd_busy_q && rd_cnt_q > 2'h1) begin
                rd_cnt_d = rd_cnt_q - 2'h1;
            end else if (rd_busy_q && rd_cnt_q == 2'h1) begin
                rd_cnt_d = 2'h0;
                dq_out_d = rd_word0_q;
                dq_oe_n_d = 1'b0;
            end else if (rd_busy_q) begin
                rd_busy_d = 1'b0;
                dq_out_d = rd_word1_q;
                dq_oe_n_d = 1'b0;
            end else begin
                dq_oe_n_d = 1'b1;
            end
        end
        if (load_rd) begin
            rd_busy_d = 1'b1;
            rd_cnt_d = dll_off_s ? LAT_DLL_OFF : LAT_DLL_ON;
            rd_word0_d = mem_q[word_index(addr_s, narrow_s, 1'b0)];
            rd_word1_d = mem_q[word_index(addr_s, narrow_s, 1'b1)];
        end
    end

    // echo pair copies the launch pair beside the data
    always_comb begin
        echo_d = use_c ? clk_s[CK_C] : clk_s[CK_K];
        echo_n_d = use_c ? clk_s[CK_CN] : clk_s[CK_KN];
        used_d = use_c;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_busy_q <= 1'b0;
            rd_cnt_q <= 2'h0;
            rd_word0_q <= DQ_RESET;
            rd_word1_q <= DQ_RESET;
            dq_out_q <= DQ_RESET;
            dq_oe_n_q <= 1'b1;
            echo_q <= 1'b0;
            echo_n_q <= 1'b0;
            used_q <= 1'b0;
        end else begin
            rd_busy_q <= rd_busy_d;
            rd_cnt_q <= rd_cnt_d;
            rd_word0_q <= rd_word0_d;
            rd_word1_q <= rd_word1_d;
            dq_out_q <= dq_out_d;
            dq_oe_n_q <= dq_oe_n_d;
            echo_q <= echo_d;
            echo_n_q <= echo_n_d;
            used_q <= used_d;
        end
    end

    // outputs straight from flops
    assign dq_out = dq_out_q;
    assign dq_oe_n = dq_oe_n_q;
    assign echo_clock = echo_q;
    assign echo_clock_n = echo_n_q;
    assign out_clk_used = used_q;

endmodule

`default_nettype wire

// ---- sim/dsb_sram_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// port checker
// ****************************************************************
module dsb_sram_port_asserts (
    input wire logic mclk,
    input wire logic rst,
    input wire logic out_clk_c,
    input wire logic load_strobe_n,
    input wire logic dll_disable,
    input wire logic [dsb_pkg::WORD_W-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic echo_clock,
    input wire logic echo_clock_n,
    input wire logic out_clk_used
);
    import dsb_pkg::*;
    logic c_q, c_d;
    logic [5:0] cc_q, cc_d, lc_q, lc_d;

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    // cycles since output clock moved and since last load
    always_comb begin
        c_d = out_clk_c;
        cc_d = (c_q != out_clk_c) ? 6'h00 : cc_q + {5'h00, ~&cc_q};
        lc_d = !load_strobe_n ? 6'h00 : lc_q + {5'h00, ~&lc_q};
        if (rst) begin
            cc_d = 6'h00;
            lc_d = 6'h3f;
        end
    end

    // register the counters
    always_ff @(posedge mclk) begin
        c_q <= c_d;
        cc_q <= cc_d;
        lc_q <= lc_d;
    end

    a_burst_two_words: assert property (
        $fell(dq_oe_n) |-> !dq_oe_n [*8])
        else $error("read burst shorter than two words");
    a_gap_after_burst: assert property (
        $rose(dq_oe_n) |-> dq_oe_n [*3])
        else $error("data pins driven again too soon");
    a_data_on_echo: assert property (
        !$stable(dq_out) |-> (echo_clock != $past(echo_clock, 2))
            || (echo_clock_n != $past(echo_clock_n, 2)))
        else $error("read data moved without an echo edge");
    a_oe_needs_load: assert property (
        !dq_oe_n |-> lc_q < 6'h20)
        else $error("data driven without a load");
    a_used_rise: assert property (
        $rose(out_clk_used) |-> cc_q < 6'h08)
        else $error("output clock flagged without toggling");
    a_used_lapse: assert property (
        cc_q > 6'h18 |-> !out_clk_used)
        else $error("output clock flag kept after it stopped");
    a_dll_on_lat: assert property (
        $fell(dq_oe_n) && !dll_disable |-> lc_q inside {[13:16]})
        else $error("wrong read latency with dll on");
    a_dll_off_lat: assert property (
        $fell(dq_oe_n) && dll_disable |-> lc_q inside {[9:12]})
        else $error("wrong read latency with dll off");
endmodule

bind dsb_sram_port dsb_sram_port_asserts u_chk (
    .mclk(mclk),
    .rst(rst),
    .out_clk_c(out_clk_c),
    .load_strobe_n(load_strobe_n),
    .dll_disable(dll_disable),
    .dq_out(dq_out),
    .dq_oe_n(dq_oe_n),
    .echo_clock(echo_clock),
    .echo_clock_n(echo_clock_n),
    .out_clk_used(out_clk_used)
);

`default_nettype wire

// ---- sim/dsb_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// memory controller model
// ****************************************************************
module dsb_ctl_model (
    output logic link_k,
    output logic link_k_n,
    output logic out_clk_c,
    output logic out_clk_c_n,
    output logic [dsb_pkg::ADDR_W-1:0] address,
    output logic load_strobe_n,
    output logic read_write,
    output logic [dsb_pkg::LANES-1:0] byte_write_select_n,
    output logic [dsb_pkg::WORD_W-1:0] dq_in,
    input wire logic [dsb_pkg::WORD_W-1:0] dq_out,
    input wire logic dq_oe_n
);
    import dsb_pkg::*;
    logic c_on = 1'b0;
    logic [WORD_W-1:0] drv;

    // free running input clock, 200 ns period
    initial begin
        link_k = 1'b0;
        out_clk_c = 1'b0;
        address = 5'h00;
        load_strobe_n = 1'b1;
        read_write = 1'b1;
        byte_write_select_n = 2'h3;
        drv = 18'h0_0000;
        #13;
        forever #100 link_k = ~link_k;
    end

    // output clock follows input clock late, stands still when off
    always @(link_k) out_clk_c <= #20 (c_on ? link_k : out_clk_c);
    assign link_k_n = ~link_k;
    assign out_clk_c_n = ~out_clk_c;
    // data pin level: device when enabled, else ours
    assign dq_in = dq_oe_n ? drv : dq_out;

    // one address, then two write beats centred on the clock rises
    task automatic go(input logic rd, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1,
                      input logic [LANES-1:0] b0, input logic [LANES-1:0] b1);
        @(negedge link_k) #50;
        address = a;
        load_strobe_n = 1'b0;
        read_write = rd;
        @(posedge link_k) #50;
        address = ~a;
        load_strobe_n = 1'b1;
        read_write = ~rd;
        if (!rd) begin
            @(negedge link_k) #50;
            drv = w0;
            byte_write_select_n = b0;
            @(posedge link_k) #50;
            drv = w1;
            byte_write_select_n = b1;
            @(negedge link_k) #50;
            drv = ~w1;
            byte_write_select_n = 2'h3;
        end
    endtask
endmodule

`default_nettype wire

// ---- sim/dsb_sram_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// port testbench
// ****************************************************************
module dsb_sram_port_tb_top;
    import dsb_pkg::*;
    localparam logic [WORD_W-1:0] W0 = 18'h1_2a5c;
    localparam logic [WORD_W-1:0] W1 = 18'h2_d3a6;
    localparam logic [WORD_W-1:0] N0 = 18'h3_0f0f;
    localparam logic [WORD_W-1:0] N1 = 18'h0_f0f1;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic dll_disable = 1'b0;
    logic narrow_org = 1'b0;
    logic link_k, link_k_n, out_clk_c, out_clk_c_n;
    logic load_strobe_n, read_write, dq_oe_n;
    logic echo_clock, echo_clock_n, out_clk_used;
    logic [ADDR_W-1:0] address;
    logic [LANES-1:0] byte_write_select_n;
    logic [WORD_W-1:0] dq_in, dq_out;
    int mismatches = 0;
    int tests_run = 0;

    dsb_sram_port dut (.mclk(mclk), .rst(rst), .link_k(link_k),
        .link_k_n(link_k_n), .out_clk_c(out_clk_c),
        .out_clk_c_n(out_clk_c_n), .address(address),
        .load_strobe_n(load_strobe_n), .read_write(read_write),
        .byte_write_select_n(byte_write_select_n), .dq_in(dq_in),
        .dll_disable(dll_disable), .narrow_org(narrow_org),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n), .echo_clock(echo_clock),
        .echo_clock_n(echo_clock_n), .out_clk_used(out_clk_used));

    dsb_ctl_model ctl (.link_k(link_k), .link_k_n(link_k_n),
        .out_clk_c(out_clk_c), .out_clk_c_n(out_clk_c_n),
        .address(address), .load_strobe_n(load_strobe_n),
        .read_write(read_write), .byte_write_select_n(byte_write_select_n),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    // system clock, 25 ns period
    initial begin
        forever #12.5 mclk = ~mclk;
    end

    // compare one value
    task automatic check(input logic [WORD_W-1:0] got,
                         input logic [WORD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // read one address, check both words at launch rise idx and idx+1
    task automatic rd_chk(input logic [ADDR_W-1:0] a,
                          input logic [WORD_W-1:0] e0,
                          input logic [WORD_W-1:0] e1, input int idx);
        ctl.go(1'b1, a, 18'h0_0000, 18'h0_0000, 2'h3, 2'h3);
        #(idx * 100);
        check(dq_oe_n, 1'b1);
        for (int i = 0; i < 2; i++) begin
            #100;
            check(dq_oe_n, 1'b0);
            check(dq_out, i ? e1 : e0);
            check(echo_clock, (idx + i) % 2 == 0);
            check(echo_clock_n, (idx + i) % 2 != 0);
        end
        #100;
        check(dq_oe_n, 1'b1);
    endtask

    // change mode pins off the clock edge
    task automatic set_mode(input logic d, input logic n);
        @(posedge mclk) #1;
        dll_disable = d;
        narrow_org = n;
    endtask

    // outputs quiet under reset
    task automatic t_reset;
        check(dq_oe_n, 1'b1);
        check(dq_out, 18'h0_0000);
        check({echo_clock, echo_clock_n, out_clk_used}, 3'h0);
    endtask

    // write a pair, read it back from both burst starts
    task automatic t_wide;
        ctl.go(1'b0, 5'h06, W0, W1, 2'h0, 2'h0);
        rd_chk(5'h06, W0, W1, 3);
        rd_chk(5'h07, W1, W0, 3);
    endtask

    // narrow start and dll off latency
    task automatic t_modes;
        set_mode(1'b0, 1'b1);
        rd_chk(5'h07, W0, W1, 3);
        set_mode(1'b1, 1'b0);
        rd_chk(5'h06, W0, W1, 2);
        set_mode(1'b0, 1'b0);
    endtask

    // one lane per beat written
    task automatic t_lanes;
        ctl.go(1'b0, 5'h06, N0, N1, 2'h2, 2'h1);
        rd_chk(5'h06, {W0[17:9], N0[8:0]}, {N1[17:9], W1[8:0]}, 3);
    endtask

    // output clock pair present, then withdrawn
    task automatic t_out_clk;
        ctl.c_on = 1'b1;
        for (int n = 0; n < 40 && out_clk_used !== 1'b1; n++) @(posedge mclk);
        #1;
        check(out_clk_used, 1'b1);
        rd_chk(5'h06, {W0[17:9], N0[8:0]}, {N1[17:9], W1[8:0]}, 3);
        ctl.c_on = 1'b0;
        #200;
        check(out_clk_used, 1'b1);
        check({echo_clock, echo_clock_n}, 2'h2);
        repeat (40) @(posedge mclk);
        #1;
        check(out_clk_used, 1'b0);
    endtask

    // counts and verdict
    task automatic results;
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        t_reset();
        rst = 1'b0;
        t_wide();
        t_modes();
        t_lanes();
        t_out_clk();
        results();
    end
endmodule

`default_nettype wire
